/* design/iord_addr_map.v */
// Address mapper: core access kind and address to I/O index and legality
`timescale 1ns/100ps
`include "iord_consts.vh"
module iord_addr_map
(
  op,
  addr,
  io_idx,
  io_hit,
  ext_hit,
  legal
);
  input wire [2:0] op;
  input wire [7:0] addr;
  output reg [5:0] io_idx;
  output reg io_hit;
  output reg ext_hit;
  output reg legal;
  reg [7:0] diff;
  always @*
  begin
    diff = addr - `IORD_DATA_OFS;
    io_idx = addr[5:0];
    io_hit = 1'b0;
    ext_hit = 1'b0;
    legal = 1'b0;
    case (op)
      `IORD_OP_IN, `IORD_OP_OUT:
      begin
        io_hit = (addr[7:6] == 2'h0);
        legal = io_hit;
      end
      `IORD_OP_SET, `IORD_OP_CLR, `IORD_OP_TEST:
      begin
        io_hit = (addr <= {2'h0, `IORD_BIT_MAX});
        legal = io_hit;
      end
      `IORD_OP_LOAD, `IORD_OP_STORE:
      begin
        if (addr >= `IORD_DATA_OFS && addr < `IORD_EXT_MIN)
        begin
          io_idx = diff[5:0];
          io_hit = 1'b1;
        end
        ext_hit = (addr >= `IORD_EXT_MIN);
        legal = io_hit | ext_hit;
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
  end
endmodule

/* design/iord_bit_unit.v */
// Bit unit: read-modify-write value for set and clear, and bit test
`timescale 1ns/100ps
module iord_bit_unit
(
  rd_val,
  bit_sel,
  set_n_clr,
  rmw_val,
  bit_val
);
  input wire [7:0] rd_val;
  input wire [2:0] bit_sel;
  input wire set_n_clr;
  output wire [7:0] rmw_val;
  output wire bit_val;
  wire [7:0] onehot;
  assign onehot = 8'h01 << bit_sel;
  // Whole register written back, so set flags go back as ones
  assign rmw_val = set_n_clr ? (rd_val | onehot) : (rd_val & ~onehot);
  assign bit_val = rd_val[bit_sel];
endmodule

/* design/iord_consts.vh */
// Constants for the I/O register space decoder
`ifndef IORD_CONSTS_VH
`define IORD_CONSTS_VH
// ==========================================
// Access kinds issued by the core
`define IORD_OP_NONE 3'h0
`define IORD_OP_IN 3'h1
`define IORD_OP_OUT 3'h2
`define IORD_OP_SET 3'h3
`define IORD_OP_CLR 3'h4
`define IORD_OP_TEST 3'h5
`define IORD_OP_LOAD 3'h6
`define IORD_OP_STORE 3'h7
// ==========================================
// Address ranges
`define IORD_BIT_MAX 6'h1f
`define IORD_IO_MAX 6'h3f
`define IORD_DATA_OFS 8'h20
`define IORD_EXT_MIN 8'h60
`define IORD_EXT_MAX 8'hff
// ==========================================
// Register offsets (I/O numbers)
`define IORD_PORT_A_PIN_INPUT 6'h00
`define IORD_PORT_A_DIRECTION 6'h01
`define IORD_PORT_A_OUTPUT_LATCH 6'h02
`define IORD_PORT_B_PIN_INPUT 6'h03
`define IORD_PORT_B_DIRECTION 6'h04
`define IORD_PORT_B_OUTPUT_LATCH 6'h05
`define IORD_PORT_C_PIN_INPUT 6'h06
`define IORD_PORT_C_DIRECTION 6'h07
`define IORD_PORT_C_OUTPUT_LATCH 6'h08
`define IORD_PORT_D_PIN_INPUT 6'h09
`define IORD_PORT_D_DIRECTION 6'h0a
`define IORD_PORT_D_OUTPUT_LATCH 6'h0b
`define IORD_TFLG0 6'h15
`define IORD_TFLG1 6'h16
`define IORD_TFLG2 6'h17
`define IORD_PCFLG 6'h1b
`define IORD_EXFLG 6'h1c
`define IORD_EXMSK 6'h1d
`define IORD_EEAH 6'h22
`define IORD_PRESC 6'h23
`define IORD_T0CA 6'h24
`define IORD_T0CB 6'h25
`define IORD_T0CNT 6'h26
`define IORD_T0CMPA 6'h27
`define IORD_T0CMPB 6'h28
`define IORD_SCR1 6'h2a
`define IORD_SCR2 6'h2b
`define IORD_SPCTL 6'h2c
`define IORD_SPSTA 6'h2d
`define IORD_SPDAT 6'h2e
`define IORD_CMPCS 6'h30
`define IORD_DBGD 6'h31
`define IORD_SLPC 6'h33
// ==========================================
// Implemented bit masks
`define IORD_M_ALL 8'hff
`define IORD_M_TFLG0 8'h07
`define IORD_M_TFLG1 8'h27
`define IORD_M_TFLG2 8'h07
`define IORD_M_PCFLG 8'h0f
`define IORD_M_EXFLG 8'h07
`define IORD_M_EXMSK 8'h07
`define IORD_M_EEAH 8'h03
`define IORD_M_PRESC 8'h83
`define IORD_M_T0CA 8'hf3
`define IORD_M_T0CB 8'hcf
`define IORD_M_SPSTA 8'h01
`define IORD_M_SPSTA_FLG 8'hc0
`define IORD_M_SLPC 8'h0f
`define IORD_RST 8'h00
`endif

/* design/iord_decoder.v */
// I/O register space decoder with register bank and extended-range port
// Function
// - Set and clear bit instructions work on I/O numbers 0x00-0x1F only.
// - Bit test and skip works on the lowest thirty-two I/O numbers.
// - Certain flags clear on writing one; writing zero leaves them.
// - Bit set or clear writes back the whole register, clearing set flags.
// - Short in and out instructions reach I/O numbers 0x00-0x3F.
// - Data-space address equals I/O number plus 0x20.
// - Extended range 0x60-0xFF reachable only by load and store.
`timescale 1ns/100ps
`include "iord_consts.vh"
module iord_decoder
(
  clk,
  rst_b,
  acc_valid,
  acc_op,
  acc_addr,
  acc_wdata,
  acc_bit,
  pin_a,
  pin_b,
  pin_c,
  pin_d,
  flag_set_t0,
  flag_set_t1,
  flag_set_t2,
  flag_set_pc,
  flag_set_ex,
  flag_set_sp,
  acc_rdata_ff,
  acc_skip_ff,
  acc_err_ff,
  ext_wr_ff,
  ext_rd_ff,
  ext_addr_ff,
  ext_wdata_ff,
  dir_a_ff,
  out_a_ff,
  dir_b_ff,
  out_b_ff,
  dir_c_ff,
  out_c_ff,
  dir_d_ff,
  out_d_ff,
  ex_mask_ff,
  slp_ctl_ff
);
  input wire clk;
  input wire rst_b;
  input wire acc_valid;
  input wire [2:0] acc_op;
  input wire [7:0] acc_addr;
  input wire [7:0] acc_wdata;
  input wire [2:0] acc_bit;
  input wire [7:0] pin_a;
  input wire [7:0] pin_b;
  input wire [7:0] pin_c;
  input wire [7:0] pin_d;
  input wire [7:0] flag_set_t0;
  input wire [7:0] flag_set_t1;
  input wire [7:0] flag_set_t2;
  input wire [7:0] flag_set_pc;
  input wire [7:0] flag_set_ex;
  input wire [7:0] flag_set_sp;
  output reg [7:0] acc_rdata_ff;
  output reg acc_skip_ff;
  output reg acc_err_ff;
  output reg ext_wr_ff;
  output reg ext_rd_ff;
  output reg [7:0] ext_addr_ff;
  output reg [7:0] ext_wdata_ff;
  output reg [7:0] dir_a_ff;
  output reg [7:0] out_a_ff;
  output reg [7:0] dir_b_ff;
  output reg [7:0] out_b_ff;
  output reg [7:0] dir_c_ff;
  output reg [7:0] out_c_ff;
  output reg [7:0] dir_d_ff;
  output reg [7:0] out_d_ff;
  output reg [7:0] ex_mask_ff;
  output reg [7:0] slp_ctl_ff;

  localparam NREG = 64;
  // ==========================================
  // Storage
  reg [7:0] bank_ff [0:NREG-1];
  reg [7:0] nxt_bank [0:NREG-1];
  wire [5:0] io_idx;
  wire io_hit;
  wire ext_hit;
  wire legal;
  wire [7:0] rmw_val;
  wire bit_val;
  reg [7:0] rd_val;
  reg [7:0] wr_val;
  reg wr_en;
  integer i;
  integer k;

  // ==========================================
  // Implemented bits per I/O number
  function [7:0] impl_mask;
    input [5:0] idx;
    begin
      case (idx)
        `IORD_PORT_A_DIRECTION, `IORD_PORT_A_OUTPUT_LATCH, `IORD_PORT_B_DIRECTION, `IORD_PORT_B_OUTPUT_LATCH,
        `IORD_PORT_C_DIRECTION, `IORD_PORT_C_OUTPUT_LATCH, `IORD_PORT_D_DIRECTION, `IORD_PORT_D_OUTPUT_LATCH,
        `IORD_T0CNT, `IORD_T0CMPA, `IORD_T0CMPB, `IORD_SCR1, `IORD_SCR2,
        `IORD_SPCTL, `IORD_SPDAT, `IORD_CMPCS, `IORD_DBGD: impl_mask = `IORD_M_ALL;
        `IORD_TFLG0: impl_mask = `IORD_M_TFLG0;
        `IORD_TFLG1: impl_mask = `IORD_M_TFLG1;
        `IORD_TFLG2: impl_mask = `IORD_M_TFLG2;
        `IORD_PCFLG: impl_mask = `IORD_M_PCFLG;
        `IORD_EXFLG: impl_mask = `IORD_M_EXFLG;
        `IORD_EXMSK: impl_mask = `IORD_M_EXMSK;
        `IORD_EEAH: impl_mask = `IORD_M_EEAH;
        `IORD_PRESC: impl_mask = `IORD_M_PRESC;
        `IORD_T0CA: impl_mask = `IORD_M_T0CA;
        `IORD_T0CB: impl_mask = `IORD_M_T0CB;
        `IORD_SPSTA: impl_mask = `IORD_M_SPSTA | `IORD_M_SPSTA_FLG;
        `IORD_SLPC: impl_mask = `IORD_M_SLPC;
        default: impl_mask = `IORD_RST;
      endcase
    end
  endfunction

  // Write-one-to-clear bits per I/O number
  function [7:0] w1c_mask;
    input [5:0] idx;
    begin
      case (idx)
        `IORD_TFLG0: w1c_mask = `IORD_M_TFLG0;
        `IORD_TFLG1: w1c_mask = `IORD_M_TFLG1;
        `IORD_TFLG2: w1c_mask = `IORD_M_TFLG2;
        `IORD_PCFLG: w1c_mask = `IORD_M_PCFLG;
        `IORD_EXFLG: w1c_mask = `IORD_M_EXFLG;
        default: w1c_mask = `IORD_RST;
      endcase
    end
  endfunction

  // Hardware flag set inputs per I/O number, passed in so the caller sees them change
  function [7:0] hw_set;
    input [5:0] idx;
    input [7:0] f_t0;
    input [7:0] f_t1;
    input [7:0] f_t2;
    input [7:0] f_pc;
    input [7:0] f_ex;
    input [7:0] f_sp;
    begin
      case (idx)
        `IORD_TFLG0: hw_set = f_t0 & `IORD_M_TFLG0;
        `IORD_TFLG1: hw_set = f_t1 & `IORD_M_TFLG1;
        `IORD_TFLG2: hw_set = f_t2 & `IORD_M_TFLG2;
        `IORD_PCFLG: hw_set = f_pc & `IORD_M_PCFLG;
        `IORD_EXFLG: hw_set = f_ex & `IORD_M_EXFLG;
        `IORD_SPSTA: hw_set = f_sp & `IORD_M_SPSTA_FLG;
        default: hw_set = `IORD_RST;
      endcase
    end
  endfunction

  // ==========================================
  // Decode
  iord_addr_map u_map
  (
    .op(acc_op),
    .addr(acc_addr),
    .io_idx(io_idx),
    .io_hit(io_hit),
    .ext_hit(ext_hit),
    .legal(legal)
  );

  iord_bit_unit u_bit
  (
    .rd_val(rd_val),
    .bit_sel(acc_bit),
    .set_n_clr(acc_op == `IORD_OP_SET),
    .rmw_val(rmw_val),
    .bit_val(bit_val)
  );

  // ==========================================
  // Read mux: pin registers show pins, reserved bits read zero
  always @*
  begin
    case (io_idx)
      `IORD_PORT_A_PIN_INPUT: rd_val = pin_a;
      `IORD_PORT_B_PIN_INPUT: rd_val = pin_b;
      `IORD_PORT_C_PIN_INPUT: rd_val = pin_c;
      `IORD_PORT_D_PIN_INPUT: rd_val = pin_d;
      default: rd_val = bank_ff[io_idx] & impl_mask(io_idx);
    endcase
  end

  // ==========================================
  // Write value selection
  always @*
  begin
    wr_en = 1'b0;
    wr_val = acc_wdata;
    if (acc_valid && legal && io_hit)
    begin
      case (acc_op)
        `IORD_OP_OUT, `IORD_OP_STORE:
        begin
          wr_en = 1'b1;
          wr_val = acc_wdata;
        end
        `IORD_OP_SET, `IORD_OP_CLR:
        begin
          wr_en = 1'b1;
          wr_val = rmw_val;
        end
        default:
        begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Next bank state; hardware set wins over software clear
  always @*
  begin
    for (i = 0; i < NREG; i = i + 1)
    begin
      nxt_bank[i] = bank_ff[i];
      if (wr_en && io_idx == i[5:0])
      begin
        nxt_bank[i] = (bank_ff[i] & w1c_mask(i[5:0]) & ~wr_val)
                    | (wr_val & impl_mask(i[5:0]) & ~w1c_mask(i[5:0]));
        if (i[5:0] == `IORD_SPSTA)
        begin
          nxt_bank[i] = (bank_ff[i] & `IORD_M_SPSTA_FLG) | (wr_val & `IORD_M_SPSTA);
        end
        if (i[5:0] == `IORD_PORT_A_PIN_INPUT || i[5:0] == `IORD_PORT_B_PIN_INPUT
            || i[5:0] == `IORD_PORT_C_PIN_INPUT || i[5:0] == `IORD_PORT_D_PIN_INPUT)
        begin
          nxt_bank[i] = bank_ff[i];
        end
      end
      nxt_bank[i] = nxt_bank[i] | hw_set(i[5:0], flag_set_t0, flag_set_t1, flag_set_t2,
                                         flag_set_pc, flag_set_ex, flag_set_sp);
    end
  end

  // ==========================================
  // Registers
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (k = 0; k < NREG; k = k + 1)
        bank_ff[k] <= `IORD_RST;
    end
    else
    begin
      for (k = 0; k < NREG; k = k + 1)
        bank_ff[k] <= nxt_bank[k];
    end
  end

  // ==========================================
  // Core answer and extended-range port
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_rdata_ff <= `IORD_RST;
      acc_skip_ff <= 1'b0;
      acc_err_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      ext_rd_ff <= 1'b0;
      ext_addr_ff <= `IORD_RST;
      ext_wdata_ff <= `IORD_RST;
    end
    else
    begin
      acc_rdata_ff <= `IORD_RST;
      acc_skip_ff <= 1'b0;
      acc_err_ff <= acc_valid && (acc_op != `IORD_OP_NONE) && !legal;
      ext_wr_ff <= acc_valid && ext_hit && acc_op == `IORD_OP_STORE;
      ext_rd_ff <= acc_valid && ext_hit && acc_op == `IORD_OP_LOAD;
      if (acc_valid && ext_hit)
      begin
        ext_addr_ff <= acc_addr;
        ext_wdata_ff <= acc_wdata;
      end
      if (acc_valid && io_hit && (acc_op == `IORD_OP_IN || acc_op == `IORD_OP_LOAD))
        acc_rdata_ff <= rd_val;
      if (acc_valid && io_hit && acc_op == `IORD_OP_TEST)
        acc_skip_ff <= (bit_val == acc_wdata[0]);
    end
  end

  // ==========================================
  // Control outputs mirror stored registers
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dir_a_ff <= `IORD_RST;
      out_a_ff <= `IORD_RST;
      dir_b_ff <= `IORD_RST;
      out_b_ff <= `IORD_RST;
      dir_c_ff <= `IORD_RST;
      out_c_ff <= `IORD_RST;
      dir_d_ff <= `IORD_RST;
      out_d_ff <= `IORD_RST;
      ex_mask_ff <= `IORD_RST;
      slp_ctl_ff <= `IORD_RST;
    end
    else
    begin
      dir_a_ff <= nxt_bank[`IORD_PORT_A_DIRECTION];
      out_a_ff <= nxt_bank[`IORD_PORT_A_OUTPUT_LATCH];
      dir_b_ff <= nxt_bank[`IORD_PORT_B_DIRECTION];
      out_b_ff <= nxt_bank[`IORD_PORT_B_OUTPUT_LATCH];
      dir_c_ff <= nxt_bank[`IORD_PORT_C_DIRECTION];
      out_c_ff <= nxt_bank[`IORD_PORT_C_OUTPUT_LATCH];
      dir_d_ff <= nxt_bank[`IORD_PORT_D_DIRECTION];
      out_d_ff <= nxt_bank[`IORD_PORT_D_OUTPUT_LATCH];
      ex_mask_ff <= nxt_bank[`IORD_EXMSK] & `IORD_M_EXMSK;
      slp_ctl_ff <= nxt_bank[`IORD_SLPC] & `IORD_M_SLPC;
    end
  end
endmodule

/* verif/iord_core_model.sv */
// Core model issuing accesses into the I/O register space
`timescale 1ns/100ps
module iord_core_model
(
  input wire clk,
  input wire [7:0] acc_rdata_ff,
  input wire acc_skip_ff,
  input wire acc_err_ff,
  input wire ext_wr_ff,
  input wire ext_rd_ff,
  output reg acc_valid = 1'b0,
  output reg [2:0] acc_op = 3'h0,
  output reg [7:0] acc_addr = 8'h00,
  output reg [7:0] acc_wdata = 8'h00,
  output reg [2:0] acc_bit = 3'h0,
  output reg [7:0] res_data = 8'h00,
  output reg [7:0] res_flags = 8'h00
);
  // Callers may pass ones in reserved bits and may access reserved addresses
  task access(input [2:0] op, input [7:0] addr, input [7:0] wd, input [2:0] bs);
  begin
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_op <= op;
    acc_addr <= addr;
    acc_wdata <= wd;
    acc_bit <= bs;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_wdata <= ~wd;
    #1;
    res_data = acc_rdata_ff;
    res_flags = {4'h0, acc_skip_ff, acc_err_ff, ext_wr_ff, ext_rd_ff};
    // Let the result ports settle before the caller reads them
    #1;
  end
  endtask
endmodule

/* verif/iord_decoder_properties.sv */
// Checker of access answers at the decoder ports
`timescale 1ns/100ps
`include "iord_consts.vh"
module iord_decoder_chk
(
  input wire clk,
  input wire rst_b,
  input wire acc_valid,
  input wire [2:0] acc_op,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire acc_skip_ff,
  input wire acc_err_ff,
  input wire ext_wr_ff,
  input wire ext_rd_ff,
  input wire [7:0] ext_addr_ff,
  input wire [7:0] ext_wdata_ff,
  input wire [7:0] out_a_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire bit_op = acc_valid && (acc_op >= `IORD_OP_SET) && (acc_op <= `IORD_OP_TEST);
  wire io_op = acc_valid && (acc_op == `IORD_OP_IN || acc_op == `IORD_OP_OUT);
  wire ls_op = acc_valid && (acc_op == `IORD_OP_LOAD || acc_op == `IORD_OP_STORE);
  // ==========================================
  // Access sequences
  sequence s_wr_port_a_output_latch;
    (io_op && acc_op == `IORD_OP_OUT && acc_addr == 8'h02)
      || (ls_op && acc_op == `IORD_OP_STORE && acc_addr == 8'h22);
  endsequence
  sequence s_ext_store;
    ls_op && acc_op == `IORD_OP_STORE && acc_addr >= `IORD_EXT_MIN;
  endsequence
  // ==========================================
  // Properties
  AST_BIT_HIGH: assert property (bit_op && acc_addr > 8'h1f |=> acc_err_ff)
    else $error("bit op above range not refused");
  AST_BIT_LOW: assert property (bit_op && acc_addr <= 8'h1f |=> !acc_err_ff)
    else $error("bit op in range refused");
  AST_IO_HIGH: assert property (io_op && acc_addr > 8'h3f |=> acc_err_ff)
    else $error("short io above range not refused");
  AST_IO_LOW: assert property (io_op && acc_addr <= 8'h3f |=> !acc_err_ff && !ext_wr_ff)
    else $error("short io in range refused");
  AST_LS_LOW: assert property (ls_op && acc_addr < 8'h20 |=> acc_err_ff)
    else $error("load store below offset not refused");
  AST_PORT_A_OUTPUT_LATCH_WR: assert property (s_wr_port_a_output_latch |=> out_a_ff == $past(acc_wdata))
    else $error("port a latch not written");
  AST_EXT_WR: assert property (s_ext_store |=> ext_wr_ff
    && ext_addr_ff == $past(acc_addr) && ext_wdata_ff == $past(acc_wdata))
    else $error("extended store not forwarded");
  AST_EXT_RD: assert property (ext_rd_ff |-> $past(acc_valid) && $past(acc_op) == 3'h6)
    else $error("extended read without load");
  AST_SKIP: assert property (acc_skip_ff |-> $past(bit_op) && $past(acc_op) == 3'h5)
    else $error("skip without bit test");
endmodule
bind iord_decoder iord_decoder_chk i_iord_decoder_chk (.clk, .rst_b, .acc_valid, .acc_op,
  .acc_addr, .acc_wdata, .acc_skip_ff, .acc_err_ff, .ext_wr_ff, .ext_rd_ff, .ext_addr_ff,
  .ext_wdata_ff, .out_a_ff);

/* verif/testbench.sv */
// Self-checking testbench of the I/O register space decoder
`timescale 1ns/100ps
`include "iord_consts.vh"
module testbench;
  localparam [2:0] op_no = `IORD_OP_NONE, op_in = `IORD_OP_IN, op_out = `IORD_OP_OUT;
  localparam [2:0] op_set = `IORD_OP_SET, op_clr = `IORD_OP_CLR, op_tst = `IORD_OP_TEST;
  localparam [2:0] op_ld = `IORD_OP_LOAD, op_st = `IORD_OP_STORE;
  localparam logic [7:0] flag_adr [0:4] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c};
  localparam logic [7:0] flag_msk [0:4] = '{8'h07, 8'h27, 8'h07, 8'h0f, 8'h07};
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] pin_a = 8'h00, pin_b = 8'h00, pin_c = 8'h00, pin_d = 8'h00;
  reg [7:0] fs [0:5];
  wire acc_valid, acc_skip_ff, acc_err_ff, ext_wr_ff, ext_rd_ff;
  wire [2:0] acc_op, acc_bit;
  wire [7:0] acc_addr, acc_wdata, acc_rdata_ff, ext_addr_ff, ext_wdata_ff, res_data, res_flags;
  wire [7:0] dir_a_ff, out_a_ff, dir_b_ff, out_b_ff, dir_c_ff, out_c_ff, dir_d_ff, out_d_ff;
  wire [7:0] ex_mask_ff, slp_ctl_ff;
  integer err_total = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer j;
  reg [7:0] k;
  always #4 clk = ~clk;
  iord_decoder i_iord_decoder (.clk, .rst_b, .acc_valid, .acc_op, .acc_addr, .acc_wdata,
    .acc_bit, .pin_a, .pin_b, .pin_c, .pin_d, .flag_set_t0(fs[0]), .flag_set_t1(fs[1]),
    .flag_set_t2(fs[2]), .flag_set_pc(fs[3]), .flag_set_ex(fs[4]), .flag_set_sp(fs[5]),
    .acc_rdata_ff, .acc_skip_ff, .acc_err_ff, .ext_wr_ff, .ext_rd_ff, .ext_addr_ff,
    .ext_wdata_ff, .dir_a_ff, .out_a_ff, .dir_b_ff, .out_b_ff, .dir_c_ff, .out_c_ff,
    .dir_d_ff, .out_d_ff, .ex_mask_ff, .slp_ctl_ff);
  iord_core_model i_iord_core_model (.clk, .acc_rdata_ff, .acc_skip_ff, .acc_err_ff,
    .ext_wr_ff, .ext_rd_ff, .acc_valid, .acc_op, .acc_addr, .acc_wdata, .acc_bit, .res_data,
    .res_flags);
  // ==========================================
  // Access and compare tasks
  task report_and_stop;
  begin
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task xfer(input [2:0] op, input [7:0] addr, input [7:0] wd, input [2:0] bs);
    i_iord_core_model.access(op, addr, wd, bs);
  endtask
  task rd(input [2:0] op, input [7:0] addr, input [7:0] exp);
  begin
    xfer(op, addr, 8'h00, 3'h0);
    chk(res_data, exp);
  end
  endtask
  task xfl(input [2:0] op, input [7:0] addr, input [7:0] wd, input [2:0] bs, input [7:0] exp);
  begin
    xfer(op, addr, wd, bs);
    chk(res_flags, exp);
  end
  endtask
  task pulse(input integer n, input [7:0] v);
  begin
    @(posedge clk);
    fs[n] <= v;
    @(posedge clk);
    fs[n] <= 8'h00;
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  // ==========================================
  // Test sequence
  initial
  begin
    for (j = 0; j < 6; j = j + 1)
      fs[j] = 8'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    pin_c <= 8'h3c;
    pin_d <= 8'h96;
    pin_a <= 8'ha5;
    pin_b <= 8'h5a;
    for (k = 8'h00; k < 8'h04; k = k + 8'h01)
    begin
      xfer(op_st, 8'h21 + k * 8'h03, 8'h11 * (k + 8'h01), 3'h0);
      xfer(op_out, 8'h02 + k * 8'h03, 8'h22 * (k + 8'h01), 3'h0);
      rd(op_in, 8'h01 + k * 8'h03, 8'h11 * (k + 8'h01));
      rd(op_ld, 8'h22 + k * 8'h03, 8'h22 * (k + 8'h01));
    end
    chk(dir_c_ff, 8'h33);
    chk(dir_a_ff, 8'h11);
    chk(dir_b_ff, 8'h22);
    chk(dir_d_ff, 8'h44);
    chk(out_c_ff, 8'h66);
    chk(out_d_ff, 8'h88);
    rd(op_in, 8'h00, 8'ha5);
    rd(op_ld, 8'h23, 8'h5a);
    xfer(op_out, 8'h06, 8'hff, 3'h0);
    rd(op_in, 8'h06, 8'h3c);
    rd(op_ld, 8'h29, 8'h96);
    xfl(op_no, 8'h02, 8'hff, 3'h0, 8'h00);
    chk(out_a_ff, 8'h22);
    $display("Test address styles done");
    xfer(op_set, 8'h05, 8'h00, 3'h7);
    chk(out_b_ff, 8'hc4);
    xfer(op_clr, 8'h05, 8'h00, 3'h2);
    chk(out_b_ff, 8'hc0);
    xfl(op_tst, 8'h05, 8'h01, 3'h7, 8'h08);
    xfl(op_tst, 8'h05, 8'h00, 3'h2, 8'h08);
    xfl(op_tst, 8'h05, 8'h01, 3'h2, 8'h00);
    xfl(op_set, 8'h1f, 8'h00, 3'h0, 8'h00);
    xfl(op_tst, 8'h20, 8'h01, 3'h0, 8'h04);
    xfl(op_set, 8'h22, 8'h00, 3'h1, 8'h04);
    rd(op_in, 8'h22, 8'h00);
    $display("Test bit access done");
    xfl(op_st, 8'h60, 8'h3c, 3'h0, 8'h02);
    chk(ext_wdata_ff, 8'h3c);
    xfl(op_ld, 8'hff, 8'h00, 3'h0, 8'h01);
    chk(ext_addr_ff, 8'hff);
    xfl(op_out, 8'h60, 8'h01, 3'h0, 8'h04);
    xfl(op_in, 8'h3f, 8'h00, 3'h0, 8'h00);
    xfl(op_ld, 8'h1f, 8'h00, 3'h0, 8'h04);
    xfl(op_ld, 8'h5f, 8'h00, 3'h0, 8'h00);
    $display("Test ranges done");
    xfer(op_out, 8'h1d, 8'hff, 3'h0);
    chk(ex_mask_ff, 8'h07);
    xfer(op_st, 8'h53, 8'hff, 3'h0);
    chk(slp_ctl_ff, 8'h0f);
    pulse(5, 8'hc0);
    xfer(op_out, 8'h2d, 8'h01, 3'h0);
    rd(op_in, 8'h2d, 8'hc1);
    for (j = 0; j < 5; j = j + 1)
    begin
      pulse(j, 8'hff);
      rd(op_in, flag_adr[j], flag_msk[j]);
      xfer(op_out, flag_adr[j], 8'h00, 3'h0);
      rd(op_in, flag_adr[j], flag_msk[j]);
      xfer(op_out, flag_adr[j], 8'h01, 3'h0);
      rd(op_in, flag_adr[j], flag_msk[j] & 8'hfe);
      xfer(op_set, flag_adr[j], 8'h00, 3'h7);
      rd(op_in, flag_adr[j], 8'h00);
    end
    pulse(4, 8'h05);
    xfer(op_clr, 8'h1c, 8'h00, 3'h1);
    rd(op_in, 8'h1c, 8'h00);
    $display("Test flags done");
    report_and_stop;
  end
endmodule
